/* File: verilog/mr0_pkg.sv */
// constants shared by both ends of the mode-register-zero link
package mr0_pkg;
  localparam int DQ_W = 8;
  localparam int A_W  = 16;
  // mode register zero field positions
  localparam int BL_LSB   = 0;
  localparam int BT_BIT   = 3;
  localparam int CL_LSB   = 4;
  localparam int TM_BIT   = 7;
  localparam int DLLR_BIT = 8;
  localparam int WR_LSB   = 9;
  localparam int PPD_BIT  = 12;
  // read/write command address bits
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // burst length field encodings
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [2:0] MR0_BA  = 3'h0;
  localparam logic [15:0] MR0_RST = 16'h0000;
  // field value plus base gives cycles
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [3:0] WR_BASE = 4'h1;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // timing
  localparam int CLK_NS    = 100;
  localparam int TWR_NS    = 15;
  localparam int TRP_NS    = 15;
  localparam int TXP_NS    = 24;
  localparam int TXPDLL_NS = 240;
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int WR_MIN     = cyc_up(TWR_NS);
  localparam int TRP_CYC    = cyc_up(TRP_NS);
  localparam int TXP_CYC    = cyc_up(TXP_NS);
  localparam int TXPDLL_CYC = cyc_up(TXPDLL_NS);
  localparam int TMRD_CYC   = 4;
  localparam int TMOD_CYC   = 12;
  localparam int TDLLK_CYC  = 512;
  localparam int SLOTS      = 8;
  localparam int CHOP_BEATS = 4;
  localparam int WR_PULL_IN = 2;
endpackage : mr0_pkg

/* File: verilog/ddr_link_if.sv */
// command/address and data link between controller and memory
`timescale 1ns/1ps
interface ddr_link_if;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic            cke;
  logic [2:0]      ba;
  logic [15:0]     addr;
  logic [7:0]      dq_dev_o;
  logic            dq_dev_oe;
  logic [7:0]      dq_ctl_o;
  logic            dq_ctl_oe;
  logic            dqs_dev_o;
  logic            dqs_dev_oe;
  logic            dqs_ctl_o;
  logic            dqs_ctl_oe;
  logic [7:0]      dq;
  logic            dqs;
  // wire level from the enables; undriven reads low
  assign dq  = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : 8'h00);
  assign dqs = dqs_dev_oe ? dqs_dev_o : (dqs_ctl_oe ? dqs_ctl_o : 1'b0);
  modport device (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dq, dqs,
                  output dq_dev_o, dq_dev_oe, dqs_dev_o, dqs_dev_oe);
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr,
                output dq_ctl_o, dq_ctl_oe, dqs_ctl_o, dqs_ctl_oe,
                input dq, dqs);
endinterface : ddr_link_if

/* File: verilog/burst_order.sv */
// column of one read beat from start column, beat index and burst type
`timescale 1ns/1ps
module burst_order (
  // selection
  input  wire logic       interleave,
  input  wire logic [2:0] start,
  input  wire logic [2:0] beat,
  // result
  output logic [2:0]      col
);
  always_comb begin
    if (interleave) begin
      col = start ^ beat;
    end else begin
      // rotate inside the four-beat group, then the other group
      col = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
    end
  end
endmodule : burst_order

/* File: verilog/mr0_device.sv */
// memory end: mode register zero and the burst behaviour it selects
`timescale 1ns/1ps
// Summary of operation
// - all command lines and bank low write register
// - controller keeps bank bit 2, A13-A15 zero
// - programmed recovery at least rounded-up tWR cycles
// - recovery field plus precharge times write auto-precharge; read auto-precharge waits precharge only
// - A3 selects sequential or interleaved order
// - A0-A1 length; on-the-fly uses A12 per command
// - read order rotates or XORs start column
// - chop read: four beats, then drivers off
// - write ignores low column bits; chop halves
// - fixed chop write starts recovery two clocks early
// - read latency equals additive plus CAS latency
// - controller keeps test-mode bit at zero
// - DLL reset bit clears itself after acting
// - controller waits DLL lock before reads
// - controller issues DLL reset after enabling
// - A12 zero freezes DLL in power-down
// - A12 one keeps DLL running in power-down
// - rewrite register only while memory idle
// - space mode sets by tMRD and tMOD
module mr0_device
  import mr0_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link to the controller
  ddr_link_if.device       lnk,
  // array side
  input  wire logic [63:0] rd_line,
  input  wire logic [3:0]  al_cycles,
  input  wire logic [3:0]  cwl_cycles,
  output logic             wr_valid,
  output logic [2:0]       wr_col,
  output logic [7:0]       wr_data,
  output logic             ap_done,
  // mode state
  output logic [15:0]      mr0_value,
  output logic [4:0]       cl_cycles,
  output logic             test_mode,
  output logic             dll_locked,
  output logic             dll_frozen,
  output logic             power_down
);
  typedef enum logic [2:0] {ST_IDLE, ST_RDW, ST_RD, ST_WRW, ST_WR, ST_REC, ST_PRE} state_e;

  state_e      state_r, state_nxt;
  logic [15:0] mr0_r, mr0_nxt;
  logic [9:0]  dll_cnt_r, dll_cnt_nxt;
  logic        locked_r, locked_nxt;
  logic [5:0]  lat_r, lat_nxt;
  logic [2:0]  slot_r, slot_nxt;
  logic [2:0]  start_r, start_nxt;
  logic        chop_r, chop_nxt;
  logic        fix4_r, fix4_nxt;
  logic        ap_r, ap_nxt;
  logic [3:0]  rec_r, rec_nxt;
  logic        pd_r, pd_nxt;
  logic [7:0]  dq_r, dq_nxt;
  logic        oe_r, oe_nxt;
  logic        wv_r, wv_nxt;
  logic [2:0]  wc_r, wc_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic        apd_r, apd_nxt;
  logic [3:0]  cmd;
  logic        live;
  logic [1:0]  bl;
  logic [2:0]  rd_col;
  logic [2:0]  last_slot;
  logic [5:0]  rl;
  logic [5:0]  wl;
  logic [3:0]  wr_cyc;

  burst_order burst_order_i (
    .interleave (mr0_r[BT_BIT]),
    .start      (start_nxt),
    .beat       (slot_nxt),
    .col        (rd_col)
  );

  always_comb begin
    cmd       = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n};
    live      = lnk.cke;
    bl        = mr0_r[BL_LSB +: 2];
    cl_cycles = 5'(mr0_r[CL_LSB +: 3]) + CL_BASE;
    rl        = 6'(al_cycles) + 6'(cl_cycles);
    wl        = 6'(al_cycles) + 6'(cwl_cycles);
    wr_cyc    = 4'(mr0_r[WR_LSB +: 3]) + WR_BASE;
    last_slot = fix4_r ? 3'(SLOTS - 1 - WR_PULL_IN) : 3'(SLOTS - 1);
    state_nxt = state_r;
    mr0_nxt   = mr0_r;
    lat_nxt   = lat_r;
    slot_nxt  = slot_r;
    start_nxt = start_r;
    chop_nxt  = chop_r;
    fix4_nxt  = fix4_r;
    ap_nxt    = ap_r;
    rec_nxt   = rec_r;
    wv_nxt    = 1'b0;
    wc_nxt    = wc_r;
    wd_nxt    = wd_r;
    apd_nxt   = 1'b0;
    // stored reset bit drops once the DLL reset has been issued
    if (mr0_r[DLLR_BIT]) begin
      mr0_nxt[DLLR_BIT] = 1'b0;
    end
    if (live && cmd == CMD_MRS && lnk.ba == MR0_BA) begin
      mr0_nxt = lnk.addr;
    end
    // DLL lock counter, held while the DLL is frozen
    dll_cnt_nxt = dll_cnt_r;
    locked_nxt  = locked_r;
    if (mr0_r[DLLR_BIT]) begin
      dll_cnt_nxt = 10'(TDLLK_CYC);
      locked_nxt  = 1'b0;
    end else if (dll_cnt_r != 10'h000 && !(pd_r && !mr0_r[PPD_BIT])) begin
      dll_cnt_nxt = dll_cnt_r - 10'h001;
      locked_nxt  = (dll_cnt_r == 10'h001);
    end
    case (state_r)
      ST_IDLE: begin
        if (live && (cmd == CMD_RD || cmd == CMD_WR)) begin
          start_nxt = lnk.addr[2:0];
          fix4_nxt  = (bl == BL_FIX4) && (cmd == CMD_WR);
          chop_nxt  = (bl == BL_FIX4) || (bl == BL_OTF && !lnk.addr[BC_BIT]);
          ap_nxt    = lnk.addr[AP_BIT];
          lat_nxt   = (cmd == CMD_RD) ? rl : wl;
          state_nxt = (cmd == CMD_RD) ? ST_RDW : ST_WRW;
        end
      end
      ST_RDW, ST_WRW: begin
        lat_nxt = lat_r - 6'h01;
        if (lat_r == 6'h01) begin
          slot_nxt  = 3'h0;
          state_nxt = (state_r == ST_RDW) ? ST_RD : ST_WR;
        end
      end
      ST_RD: begin
        slot_nxt = slot_r + 3'h1;
        if (slot_r == 3'(SLOTS - 1)) begin
          rec_nxt   = 4'(TRP_CYC);
          state_nxt = ap_r ? ST_PRE : ST_IDLE;
        end
      end
      ST_WR: begin
        slot_nxt = slot_r + 3'h1;
        // low column bits are ignored; chop keeps one half
        if (!chop_r || slot_r < 3'(CHOP_BEATS)) begin
          wv_nxt = 1'b1;
          wc_nxt = chop_r ? {start_r[2], slot_r[1:0]} : slot_r;
          wd_nxt = lnk.dq;
        end
        if (slot_r == last_slot) begin
          rec_nxt   = wr_cyc;
          state_nxt = ap_r ? ST_REC : ST_IDLE;
        end
      end
      ST_REC: begin
        rec_nxt = rec_r - 4'h1;
        if (rec_r == 4'h1) begin
          rec_nxt   = 4'(TRP_CYC);
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        rec_nxt = rec_r - 4'h1;
        if (rec_r == 4'h1) begin
          apd_nxt   = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    pd_nxt = (state_r == ST_IDLE) && !lnk.cke;
    // drive only the first four slots of a chopped read
    oe_nxt = (state_nxt == ST_RD) && (!chop_nxt || slot_nxt < 3'(CHOP_BEATS));
  end

  // kept apart so the column decode does not loop back into the state logic
  assign dq_nxt = oe_nxt ? rd_line[{rd_col, 3'b000} +: DQ_W] : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      mr0_r     <= MR0_RST;
      dll_cnt_r <= 10'h000;
      locked_r  <= 1'b0;
      lat_r     <= 6'h00;
      slot_r    <= 3'h0;
      start_r   <= 3'h0;
      chop_r    <= 1'b0;
      fix4_r    <= 1'b0;
      ap_r      <= 1'b0;
      rec_r     <= 4'h0;
      pd_r      <= 1'b0;
      dq_r      <= 8'h00;
      oe_r      <= 1'b0;
      wv_r      <= 1'b0;
      wc_r      <= 3'h0;
      wd_r      <= 8'h00;
      apd_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      mr0_r     <= mr0_nxt;
      dll_cnt_r <= dll_cnt_nxt;
      locked_r  <= locked_nxt;
      lat_r     <= lat_nxt;
      slot_r    <= slot_nxt;
      start_r   <= start_nxt;
      chop_r    <= chop_nxt;
      fix4_r    <= fix4_nxt;
      ap_r      <= ap_nxt;
      rec_r     <= rec_nxt;
      pd_r      <= pd_nxt;
      dq_r      <= dq_nxt;
      oe_r      <= oe_nxt;
      wv_r      <= wv_nxt;
      wc_r      <= wc_nxt;
      wd_r      <= wd_nxt;
      apd_r     <= apd_nxt;
    end
  end

  assign lnk.dq_dev_o   = dq_r;
  assign lnk.dq_dev_oe  = oe_r;
  assign lnk.dqs_dev_o  = oe_r;
  assign lnk.dqs_dev_oe = oe_r;
  assign wr_valid       = wv_r;
  assign wr_col         = wc_r;
  assign wr_data        = wd_r;
  assign ap_done        = apd_r;
  assign mr0_value      = mr0_r;
  assign test_mode      = mr0_r[TM_BIT];
  assign dll_locked     = locked_r;
  assign dll_frozen     = pd_r && !mr0_r[PPD_BIT];
  assign power_down     = pd_r;
endmodule : mr0_device

/* File: verilog/mr0_ctrl.sv */
// controller end: programs mode register zero and runs bursts
`timescale 1ns/1ps
module mr0_ctrl
  import mr0_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link to the memory
  ddr_link_if.ctrl         lnk,
  // mode set request
  input  wire logic        mrs_req,
  input  wire logic [1:0]  mrs_bl,
  input  wire logic        mrs_interleave,
  input  wire logic [2:0]  mrs_cl,
  input  wire logic [2:0]  mrs_wr,
  input  wire logic        mrs_dll_reset,
  input  wire logic        mrs_ppd_fast,
  // burst request
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [2:0]  col,
  input  wire logic        chop,
  input  wire logic        auto_pre,
  input  wire logic [63:0] wr_line,
  input  wire logic [3:0]  al_cycles,
  input  wire logic [3:0]  cwl_cycles,
  input  wire logic        pd_req,
  // status and read data
  output logic             ready,
  output logic             rd_ready,
  output logic             dll_ready,
  output logic             rd_valid,
  output logic [7:0]       rd_data
);
  typedef enum logic [1:0] {C_IDLE, C_BUSY, C_PD} cstate_e;

  cstate_e     st_r, st_nxt;
  logic [3:0]  cmd_r, cmd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic        cke_r, cke_nxt;
  logic [3:0]  tmrd_r, tmrd_nxt;
  logic [3:0]  tmod_r, tmod_nxt;
  logic [9:0]  dllk_r, dllk_nxt;
  logic        dlld_r, dlld_nxt;
  logic [3:0]  xp_r, xp_nxt;
  logic [6:0]  cnt_r, cnt_nxt;
  logic [6:0]  lat_r, lat_nxt;
  logic [6:0]  end_r, end_nxt;
  logic        wr_r, wr_nxt;
  logic        chop_r, chop_nxt;
  logic [2:0]  col_r, col_nxt;
  logic [1:0]  sbl_r, sbl_nxt;
  logic [2:0]  scl_r, scl_nxt;
  logic [3:0]  swr_r, swr_nxt;
  logic        sppd_r, sppd_nxt;
  logic [7:0]  dq_r, dq_nxt;
  logic        oe_r, oe_nxt;
  logic        rv_r, rv_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic [2:0]  wr_eff;
  logic [6:0]  slot;
  logic        dll_rst;

  always_comb begin
    ready    = (st_r == C_IDLE) && cke_r && tmrd_r == 4'h0 && tmod_r == 4'h0 && xp_r == 4'h0;
    rd_ready = ready && dllk_r == 10'h000;
    wr_eff   = (4'(WR_MIN) > 4'(mrs_wr) + WR_BASE) ? 3'(4'(WR_MIN) - WR_BASE) : mrs_wr;
    dll_rst  = mrs_dll_reset || !dlld_r;
    st_nxt   = st_r;
    cmd_nxt  = CMD_NOP;
    addr_nxt = addr_r;
    cke_nxt  = cke_r;
    tmrd_nxt = (tmrd_r != 4'h0) ? tmrd_r - 4'h1 : 4'h0;
    tmod_nxt = (tmod_r != 4'h0) ? tmod_r - 4'h1 : 4'h0;
    dllk_nxt = (dllk_r != 10'h000) ? dllk_r - 10'h001 : 10'h000;
    xp_nxt   = (xp_r != 4'h0) ? xp_r - 4'h1 : 4'h0;
    dlld_nxt = dlld_r;
    cnt_nxt  = cnt_r + 7'h01;
    lat_nxt  = lat_r;
    end_nxt  = end_r;
    wr_nxt   = wr_r;
    chop_nxt = chop_r;
    col_nxt  = col_r;
    sbl_nxt  = sbl_r;
    scl_nxt  = scl_r;
    swr_nxt  = swr_r;
    sppd_nxt = sppd_r;
    case (st_r)
      C_IDLE: begin
        if (mrs_req && ready) begin
          cmd_nxt  = CMD_MRS;
          // reserved bits and test mode held at zero
          addr_nxt = {3'h0, mrs_ppd_fast, wr_eff, dll_rst, 1'b0, mrs_cl,
                      mrs_interleave, 1'b0, mrs_bl};
          tmrd_nxt = 4'(TMRD_CYC);
          tmod_nxt = 4'(TMOD_CYC);
          if (dll_rst) begin
            dllk_nxt = 10'(TDLLK_CYC);
          end
          dlld_nxt = 1'b1;
          sbl_nxt  = mrs_bl;
          scl_nxt  = mrs_cl;
          swr_nxt  = 4'(wr_eff) + WR_BASE;
          sppd_nxt = mrs_ppd_fast;
        end else if ((wr_req && ready) || (rd_req && rd_ready)) begin
          wr_nxt   = wr_req;
          cmd_nxt  = wr_req ? CMD_WR : CMD_RD;
          addr_nxt = {3'h0, !chop, 1'b0, auto_pre, 7'h00, col};
          chop_nxt = (sbl_r == BL_FIX4) || (sbl_r == BL_OTF && chop);
          col_nxt  = col;
          lat_nxt  = wr_req ? 7'(al_cycles) + 7'(cwl_cycles)
                            : 7'(al_cycles) + 7'(scl_r) + 7'(CL_BASE);
          end_nxt  = lat_nxt + 7'(SLOTS + 2) + (auto_pre ? 7'(swr_r) + 7'(TRP_CYC) : 7'h00);
          cnt_nxt  = 7'h00;
          st_nxt   = C_BUSY;
        end else if (pd_req && ready) begin
          cke_nxt = 1'b0;
          st_nxt  = C_PD;
        end
      end
      C_BUSY: begin
        if (cnt_r == end_r) begin
          st_nxt = C_IDLE;
        end
      end
      C_PD: begin
        if (!pd_req) begin
          cke_nxt = 1'b1;
          xp_nxt  = sppd_r ? 4'(TXP_CYC) : 4'(TXPDLL_CYC);
          st_nxt  = C_IDLE;
        end
      end
      default: begin
        st_nxt = C_IDLE;
      end
    endcase
    // write beat k leaves one cycle after the memory's latency plus k
    slot   = cnt_nxt - lat_r - 7'h01;
    oe_nxt = (st_r == C_BUSY) && wr_r && cnt_nxt > lat_r && slot < 7'(SLOTS)
             && (!chop_r || slot < 7'(CHOP_BEATS));
    dq_nxt = oe_nxt ? wr_line[{(chop_r ? {col_r[2], slot[1:0]} : slot[2:0]), 3'b000} +: DQ_W] : 8'h00;
    rv_nxt = lnk.dqs && !oe_r;
    rd_nxt = lnk.dq;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r   <= C_IDLE;
      cmd_r  <= CMD_NOP;
      addr_r <= 16'h0000;
      cke_r  <= 1'b1;
      tmrd_r <= 4'h0;
      tmod_r <= 4'h0;
      dllk_r <= 10'h000;
      dlld_r <= 1'b0;
      xp_r   <= 4'h0;
      cnt_r  <= 7'h00;
      lat_r  <= 7'h00;
      end_r  <= 7'h00;
      wr_r   <= 1'b0;
      chop_r <= 1'b0;
      col_r  <= 3'h0;
      sbl_r  <= BL_FIX8;
      scl_r  <= 3'h0;
      swr_r  <= WR_BASE;
      sppd_r <= 1'b0;
      dq_r   <= 8'h00;
      oe_r   <= 1'b0;
      rv_r   <= 1'b0;
      rd_r   <= 8'h00;
    end else begin
      st_r   <= st_nxt;
      cmd_r  <= cmd_nxt;
      addr_r <= addr_nxt;
      cke_r  <= cke_nxt;
      tmrd_r <= tmrd_nxt;
      tmod_r <= tmod_nxt;
      dllk_r <= dllk_nxt;
      dlld_r <= dlld_nxt;
      xp_r   <= xp_nxt;
      cnt_r  <= cnt_nxt;
      lat_r  <= lat_nxt;
      end_r  <= end_nxt;
      wr_r   <= wr_nxt;
      chop_r <= chop_nxt;
      col_r  <= col_nxt;
      sbl_r  <= sbl_nxt;
      scl_r  <= scl_nxt;
      swr_r  <= swr_nxt;
      sppd_r <= sppd_nxt;
      dq_r   <= dq_nxt;
      oe_r   <= oe_nxt;
      rv_r   <= rv_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd_r;
  assign lnk.ba         = MR0_BA;
  assign lnk.addr       = addr_r;
  assign lnk.cke        = cke_r;
  assign lnk.dq_ctl_o   = dq_r;
  assign lnk.dq_ctl_oe  = oe_r;
  assign lnk.dqs_ctl_o  = oe_r;
  assign lnk.dqs_ctl_oe = oe_r;
  assign dll_ready      = dlld_r && dllk_r == 10'h000;
  assign rd_valid       = rv_r;
  assign rd_data        = rd_r;
endmodule : mr0_ctrl

/* File: bench/mr0_link_chk.sv */
// concurrent checks on the command and data link between the two ends
`timescale 1ns/1ps
module mr0_link_chk
  import mr0_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // command link
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        cke,
  input wire logic [2:0]  ba,
  input wire logic [15:0] addr,
  // data link
  input wire logic        dq_dev_oe,
  input wire logic        dqs_dev_oe,
  // latency setting
  input wire logic [3:0]  al_cycles
);
  logic [3:0] cmd;
  logic       mrs_cmd;
  logic       rd_cmd;
  logic       valid_cmd;
  logic [1:0] bl_r;
  logic [2:0] cl_r;
  logic       ppd_r;
  logic       chop_r;
  logic [9:0] since_mrs_r;
  logic [9:0] since_dll_r;
  logic [7:0] since_rd_r;
  logic [3:0] oe_run_r;
  logic [3:0] cke_hi_r;
  assign cmd       = {cs_n, ras_n, cas_n, we_n};
  assign mrs_cmd   = cke && cmd == CMD_MRS;
  assign rd_cmd    = cke && cmd == CMD_RD;
  assign valid_cmd = cke && !cs_n && cmd != CMD_NOP;
  // cycle counters since the last event of each kind; all but the drive-run count oe_run_r saturate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bl_r        <= 2'h0;
      cl_r        <= 3'h0;
      ppd_r       <= 1'b0;
      chop_r      <= 1'b0;
      since_mrs_r <= 10'h3ff;
      since_dll_r <= 10'h000;
      since_rd_r  <= 8'h00;
      oe_run_r    <= 4'h0;
      cke_hi_r    <= 4'hf;
    end else begin
      since_mrs_r <= mrs_cmd ? 10'h001 : since_mrs_r + {9'h0, since_mrs_r != 10'h3ff};
      since_dll_r <= (mrs_cmd && addr[DLLR_BIT]) ? 10'h001 : since_dll_r + {9'h0, since_dll_r != 10'h3ff};
      since_rd_r  <= rd_cmd ? 8'h01 : since_rd_r + {7'h0, since_rd_r != 8'hff};
      oe_run_r    <= dq_dev_oe ? oe_run_r + 4'h1 : 4'h0;
      cke_hi_r    <= !cke ? 4'h0 : cke_hi_r + {3'h0, cke_hi_r != 4'hf};
      if (mrs_cmd) begin
        bl_r  <= addr[1:0];
        cl_r  <= addr[6:4];
        ppd_r <= addr[PPD_BIT];
      end
      if (rd_cmd) begin
        chop_r <= bl_r == BL_FIX4 || (bl_r == BL_OTF && !addr[BC_BIT]);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_mrs_fields;
    mrs_cmd |-> ba == MR0_BA && addr[15:13] == 3'h0 && !addr[TM_BIT] && !dq_dev_oe
                && addr[WR_LSB +: 3] + WR_BASE >= WR_MIN;
  endproperty
  a_mrs_fields: assert property (p_mrs_fields) else $error("mode set with reserved or test bits");
  property p_mrd;
    mrs_cmd |-> since_mrs_r >= TMRD_CYC;
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode sets too close");
  property p_mod;
    valid_cmd && !mrs_cmd |-> since_mrs_r >= TMOD_CYC;
  endproperty
  a_mod: assert property (p_mod) else $error("command too soon after mode set");
  property p_dll_lock;
    rd_cmd |-> since_dll_r >= TDLLK_CYC;
  endproperty
  a_dll_lock: assert property (p_dll_lock) else $error("read before dll lock");
  property p_read_latency;
    $rose(dq_dev_oe) |-> since_rd_r == al_cycles + cl_r + CL_BASE + 1;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data at wrong latency");
  property p_read_len;
    $fell(dq_dev_oe) |-> oe_run_r == (chop_r ? 4'h4 : 4'h8);
  endproperty
  a_read_len: assert property (p_read_len) else $error("read burst length wrong");
  property p_strobe;
    dqs_dev_oe == dq_dev_oe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe and data drivers differ");
  property p_pd_exit;
    valid_cmd |-> cke_hi_r >= (ppd_r ? TXP_CYC : TXPDLL_CYC);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("command too soon after power-down exit");
endmodule : mr0_link_chk

/* File: bench/ddr3_mode_register_zero_tb.sv */
// self-checking bench for controller and memory joined by the link
`timescale 1ns/1ps
module ddr3_mode_register_zero_tb;
  import mr0_pkg::*;
  logic        clk, reset_n, mrs_req, mrs_interleave, mrs_dll_reset, mrs_ppd_fast, rd_req, wr_req;
  logic        chop, auto_pre, pd_req, ready, rd_ready, dll_ready, rd_valid, wr_valid, ap_done;
  logic        test_mode, dll_locked, dll_frozen, power_down, test_mode2;
  logic [1:0]  mrs_bl;
  logic [2:0]  mrs_cl, mrs_wr, col, wr_col;
  logic [3:0]  al_cycles, cwl_cycles, flags;
  logic [4:0]  cl_cycles;
  logic [7:0]  rd_data, wr_data;
  logic [15:0] mr0_value, mr0_value2;
  logic [63:0] wr_line, rd_line;
  int          miscompares, compares, cycles, il, b, c, g, g0;
  assign flags = {dll_ready, power_down, rd_ready, ready};
  ddr_link_if ddr_link_if_i ();
  ddr_link_if fault_link ();
  mr0_ctrl mr0_ctrl_i (.lnk(ddr_link_if_i), .*);
  mr0_device mr0_device_i (.lnk(ddr_link_if_i), .*);
  mr0_device mr0_device_i2 (.clk(clk), .reset_n(reset_n), .lnk(fault_link), .rd_line(rd_line),
    .al_cycles(al_cycles), .cwl_cycles(cwl_cycles), .wr_valid(), .wr_col(), .wr_data(), .ap_done(),
    .mr0_value(mr0_value2), .cl_cycles(), .test_mode(test_mode2), .dll_locked(), .dll_frozen(), .power_down());
  mr0_link_chk mr0_link_chk_i (.clk(clk), .reset_n(reset_n), .cs_n(ddr_link_if_i.cs_n),
    .ras_n(ddr_link_if_i.ras_n), .cas_n(ddr_link_if_i.cas_n), .we_n(ddr_link_if_i.we_n),
    .cke(ddr_link_if_i.cke), .ba(ddr_link_if_i.ba), .addr(ddr_link_if_i.addr),
    .dq_dev_oe(ddr_link_if_i.dq_dev_oe), .dqs_dev_oe(ddr_link_if_i.dqs_dev_oe), .al_cycles(al_cycles));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic final_report;
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait on one of the status flags
  task automatic wait_on(input int which);
    int n;
    n = 0;
    while (n < 2000 && flags[which] !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    cmp({15'h0, flags[which]}, 16'h0001);
  endtask : wait_on
  task automatic mode_set(input logic [1:0] bl, input logic il_s, input logic [2:0] cl, wr, input logic ppd);
    wait_on(0);
    @(posedge clk);
    mrs_req <= 1'b1;
    mrs_bl <= bl;
    mrs_interleave <= il_s;
    mrs_cl <= cl;
    mrs_wr <= wr;
    mrs_ppd_fast <= ppd;
    @(posedge clk);
    mrs_req <= 1'b0;
    repeat (2) @(negedge clk);
    wait_on(0);
    cmp(mr0_value, {3'h0, ppd, wr, 2'h0, cl, il_s, 1'b0, bl});
    cmp({11'h0, cl_cycles}, {13'h0, cl} + 16'h4);
  endtask : mode_set
  task automatic rd(input logic [2:0] c_s, input logic ch, il_s, short);
    int n;
    logic [2:0] e;
    n = 0;
    wait_on(1);
    @(posedge clk);
    rd_req <= 1'b1;
    col <= c_s;
    chop <= ch;
    @(posedge clk);
    rd_req <= 1'b0;
    repeat (40) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        e = il_s ? c_s ^ 3'(n) : {c_s[2] ^ n[2], c_s[1:0] + n[1:0]};
        cmp({8'h0, rd_data}, {8'h0, 8'ha0 + {5'h0, e}});
        n++;
      end
    end
    cmp(16'(n), short ? 16'h4 : 16'h8);
  endtask : rd
  task automatic wr(input logic [2:0] c_s, input logic ch, short, output int gap);
    int n, k, last;
    logic [2:0] e;
    n = 0;
    last = 0;
    gap = -100;
    wait_on(0);
    @(posedge clk);
    wr_req <= 1'b1;
    col <= c_s;
    chop <= ch;
    @(posedge clk);
    wr_req <= 1'b0;
    for (k = 0; k < 60; k++) begin
      @(negedge clk);
      if (wr_valid === 1'b1) begin
        e = short ? {c_s[2], n[1:0]} : 3'(n);
        cmp({13'h0, wr_col}, {13'h0, e});
        cmp({8'h0, wr_data}, {8'h0, 8'h50 + {5'h0, e}});
        n++;
        last = k;
      end
      if (ap_done === 1'b1) gap = k - last;
    end
    cmp(16'(n), short ? 16'h4 : 16'h8);
  endtask : wr
  task automatic pd(input logic fast);
    wait_on(0);
    @(posedge clk);
    pd_req <= 1'b1;
    @(negedge clk);
    wait_on(2);
    cmp({15'h0, dll_frozen}, {15'h0, ~fast});
    @(posedge clk);
    pd_req <= 1'b0;
    rd(3'h1, 1'b0, 1'b0, 1'b0);
  endtask : pd
  // mode set sent straight to the second memory, breaking controller rules on purpose
  task automatic raw_mrs(input logic [2:0] ba_s, input logic [15:0] a, exp_mr, input logic exp_tm);
    @(posedge clk);
    {fault_link.cs_n, fault_link.ras_n, fault_link.cas_n, fault_link.we_n} <= CMD_MRS;
    fault_link.ba <= ba_s;
    fault_link.addr <= a;
    @(posedge clk);
    {fault_link.cs_n, fault_link.ras_n, fault_link.cas_n, fault_link.we_n} <= CMD_NOP;
    fault_link.addr <= ~a;
    repeat (2) @(negedge clk);
    cmp(mr0_value2, exp_mr);
    cmp({15'h0, test_mode2}, {15'h0, exp_tm});
  endtask : raw_mrs
  initial begin
    reset_n = 1'b0;
    {mrs_req, mrs_interleave, mrs_ppd_fast, rd_req, wr_req, chop, pd_req} = 7'h00;
    {mrs_dll_reset, auto_pre} = 2'h3;
    {mrs_bl, mrs_cl, mrs_wr, col} = 11'h000;
    al_cycles = 4'h0;
    cwl_cycles = 4'h5;
    rd_line = 64'ha7a6a5a4a3a2a1a0;
    wr_line = 64'h5756555453525150;
    {fault_link.cs_n, fault_link.ras_n, fault_link.cas_n, fault_link.we_n} = CMD_NOP;
    {fault_link.cke, fault_link.ba, fault_link.addr} = 20'h80000;
    {fault_link.dq_ctl_o, fault_link.dq_ctl_oe, fault_link.dqs_ctl_o, fault_link.dqs_ctl_oe} = 11'h000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    raw_mrs(3'h4, 16'h0001, 16'h0000, 1'b0);
    raw_mrs(3'h1, 16'h0002, 16'h0000, 1'b0);
    raw_mrs(3'h0, 16'h0085, 16'h0085, 1'b1);
    raw_mrs(3'h0, 16'h0132, 16'h0032, 1'b0);
    mode_set(BL_FIX8, 1'b0, 3'h0, 3'h0, 1'b0);
    @(posedge clk);
    mrs_dll_reset <= 1'b0;
    cmp({15'h0, dll_locked}, 16'h0000);
    wait_on(3);
    // memory counts lock from its own reset action, two cycles after the controller
    repeat (2) @(negedge clk);
    cmp({15'h0, dll_locked}, 16'h0001);
    for (il = 0; il < 2; il++) begin
      @(posedge clk);
      al_cycles <= 4'(2 * il);
      for (b = 0; b < 3; b++) begin
        mode_set(2'(b), 1'(il), 3'(b + il), 3'h0, 1'b0);
        for (c = 0; c < 8; c++) rd(3'(c), c[0], 1'(il), 2'(b) == BL_FIX4 || (2'(b) == BL_OTF && c[0]));
      end
    end
    @(posedge clk);
    al_cycles <= 4'h0;
    mode_set(BL_FIX8, 1'b0, 3'h0, 3'h0, 1'b0);
    wr(3'h3, 1'b0, 1'b0, g0);
    mode_set(BL_FIX8, 1'b0, 3'h0, 3'h5, 1'b0);
    wr(3'h3, 1'b0, 1'b0, g);
    cmp(16'(g), 16'(g0 + 5));
    mode_set(BL_FIX4, 1'b0, 3'h0, 3'h0, 1'b0);
    wr(3'h5, 1'b0, 1'b1, g);
    cmp(16'(g), 16'(g0 + 2));
    mode_set(BL_OTF, 1'b0, 3'h0, 3'h0, 1'b0);
    wr(3'h6, 1'b1, 1'b1, g);
    cmp(16'(g), 16'(g0 + 4));
    wr(3'h2, 1'b0, 1'b0, g);
    cmp(16'(g), 16'(g0));
    mode_set(BL_FIX8, 1'b0, 3'h0, 3'h0, 1'b1);
    pd(1'b1);
    mode_set(BL_FIX8, 1'b0, 3'h0, 3'h0, 1'b0);
    pd(1'b0);
    final_report();
  end
endmodule : ddr3_mode_register_zero_tb
